// [bench/acc_ain_model.sv]
// Analog front-end model that returns a fixed word for whichever input the mux selects.
`timescale 1ns/1ps
module acc_ain_model
  import acc_pkg::*;
#(
  parameter logic [N_CHAN*AIN_W-1:0] VALS = '0
) (
  // Mux control from the block.
  input  wire logic [CH_W-1:0]  mux_select_r,
  // Word of the selected input.
  output logic      [AIN_W-1:0] selected_analog_input
);
  // Only the selected source reaches the shared converter.
  assign selected_analog_input = VALS[mux_select_r*AIN_W +: AIN_W];
endmodule : acc_ain_model

// [bench/testbench.sv]
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import acc_pkg::*;
  // Channel 0 is below ground and channel 4 above the reference.
  localparam logic [95:0] VALS = {12'h200, 12'h001, 12'h2A7, 12'h7FF, 12'h3FF, 12'h155, 12'h000, 12'hFFB};
  logic             sys_clk, rst_b, sw_start_set, sw_done_clear, converter_enable, quiet_convert_select;
  logic             done_irq_enable, double_speed, start_busy_bit_r, conv_done_flag_r, adc_irq_r;
  logic             analog_standby_r, cpu_halt_r;
  logic [CH_W-1:0]  channel_select, mux_select_r;
  logic [PRS_W-1:0] prescale_value;
  logic [REG_W-1:0] analog_pin_config, result_high_reg_r, result_low_reg_r, pin_analog_r;
  logic [OTH_W-1:0] other_irq_req, other_irq_out_r;
  logic [AIN_W-1:0] selected_analog_input;
  int               n_mismatch = 0;
  int               n_checks = 0;

  acc_top acc_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .sw_start_set(sw_start_set),
    .sw_done_clear(sw_done_clear), .converter_enable(converter_enable),
    .quiet_convert_select(quiet_convert_select), .channel_select(channel_select),
    .done_irq_enable(done_irq_enable), .prescale_value(prescale_value), .double_speed(double_speed),
    .analog_pin_config(analog_pin_config), .other_irq_req(other_irq_req),
    .selected_analog_input(selected_analog_input), .start_busy_bit_r(start_busy_bit_r),
    .conv_done_flag_r(conv_done_flag_r), .adc_irq_r(adc_irq_r), .result_high_reg_r(result_high_reg_r),
    .result_low_reg_r(result_low_reg_r), .mux_select_r(mux_select_r), .analog_standby_r(analog_standby_r),
    .pin_analog_r(pin_analog_r), .cpu_halt_r(cpu_halt_r), .other_irq_out_r(other_irq_out_r));
  acc_ain_model #(.VALS(VALS)) acc_ain_model_inst (.mux_select_r(mux_select_r),
    .selected_analog_input(selected_analog_input));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick

  function automatic logic [9:0] sat(input logic [11:0] v);
    if (v[11]) return RES_ZERO;
    if (v > 12'h3FF) return RES_FULL;
    return v[9:0];
  endfunction : sat

  // One conversion; spur repeats the start while busy and clears done on the completion edge.
  // Another interrupt source fires mid-run.
  task automatic conv(input logic [2:0] ch, input logic q, input logic irq_en, input logic spur);
    int         n;
    int         p;
    logic [9:0] r;
    p = (prescale_value == 5'h00 ? 1 : int'(prescale_value)) * (double_speed ? DIV_X2 : DIV_STD);
    channel_select = ch;
    quiet_convert_select = q;
    done_irq_enable = irq_en;
    sw_start_set = 1'b1;
    tick(1);
    sw_start_set = 1'b0;
    channel_select = ch + 3'h1;
    tick(1);
    `CHK(start_busy_bit_r, 1'b1)
    `CHK(mux_select_r, ch)
    `CHK(cpu_halt_r, q)
    sw_start_set = spur;
    tick(1);
    sw_start_set = 1'b0;
    n = 2;
    while (conv_done_flag_r !== 1'b1 && n < TOTAL_CYC) begin
      `CHK(start_busy_bit_r, 1'b1)
      other_irq_req = (n == 100) ? 8'h08 : 8'h00;
      sw_done_clear = spur && n == SETUP_CYC + CONV_CLKS * p;
      tick(1);
      n++;
      if (n == 101) `CHK(other_irq_out_r, q ? 8'h00 : 8'h08)
    end
    sw_done_clear = 1'b0;
    if (n >= TOTAL_CYC) begin
      n_mismatch++;
      give_verdict();
    end
    `CHK(n >= SETUP_CYC + CONV_CLKS * p && n <= SETUP_CYC + CONV_CLKS * p + 2, 1'b1)
    `CHK(n < TOTAL_CYC, 1'b1)
    `CHK(start_busy_bit_r, 1'b0)
    `CHK(cpu_halt_r, 1'b0)
    `CHK(other_irq_out_r, q ? 8'h08 : 8'h00)
    r = sat(VALS[ch*12 +: 12]);
    if (!q) r = r & STD_MASK;
    `CHK(result_high_reg_r, r[9:2])
    `CHK(result_low_reg_r, {6'h00, r[1:0]})
    `CHK(adc_irq_r, irq_en)
    tick(2);
    `CHK(conv_done_flag_r, 1'b1)
    sw_done_clear = 1'b1;
    tick(1);
    sw_done_clear = 1'b0;
    tick(1);
    `CHK(conv_done_flag_r, 1'b0)
    `CHK(adc_irq_r, 1'b0)
  endtask : conv

  task automatic check_pins_standby;
    analog_pin_config = 8'hA5;
    tick(2);
    `CHK(pin_analog_r, 8'hA5)
    analog_pin_config = 8'h5A;
    converter_enable = 1'b0;
    tick(2);
    `CHK(pin_analog_r, 8'h5A)
    `CHK(analog_standby_r, 1'b1)
    sw_start_set = 1'b1;
    tick(1);
    sw_start_set = 1'b0;
    tick(3);
    `CHK(start_busy_bit_r, 1'b0)
    converter_enable = 1'b1;
    tick(2);
    `CHK(analog_standby_r, 1'b0)
  endtask : check_pins_standby

  // A conversion cut by standby leaves no result and no done flag.
  task automatic abort_conv;
    channel_select = 3'h3;
    sw_start_set = 1'b1;
    tick(1);
    sw_start_set = 1'b0;
    tick(20);
    `CHK(start_busy_bit_r, 1'b1)
    converter_enable = 1'b0;
    tick(2);
    `CHK(start_busy_bit_r, 1'b0)
    `CHK(conv_done_flag_r, 1'b0)
    converter_enable = 1'b1;
    tick(2);
    `CHK(result_high_reg_r, 8'h00)
  endtask : abort_conv

  initial begin
    rst_b = 1'b0;
    sw_start_set = 1'b0;
    sw_done_clear = 1'b0;
    converter_enable = 1'b1;
    quiet_convert_select = 1'b0;
    channel_select = 3'h0;
    done_irq_enable = 1'b0;
    // The slowest divider keeps the converter clock as low as this system clock allows.
    prescale_value = 5'h1F;
    double_speed = 1'b0;
    analog_pin_config = 8'hFF;
    other_irq_req = 8'h00;
    tick(12);
    rst_b = 1'b1;
    tick(2);
    `CHK(conv_done_flag_r, 1'b0)
    `CHK(result_high_reg_r, 8'h00)
    check_pins_standby();
    abort_conv();
    for (int c = 0; c < 8; c++) conv(c[2:0], 1'b0, c[0], c[1]);
    // Double speed halves the divider for the precision runs.
    double_speed = 1'b1;
    // Precision runs always enable the done interrupt; completion ends the halt with or without it.
    conv(3'h2, 1'b1, 1'b1, 1'b1);
    conv(3'h5, 1'b1, 1'b1, 1'b0);
    // Every conversion has ended before the run stops.
    give_verdict();
  end
endmodule : testbench

// [hdl/acc_clkdiv.sv]
// Converter clock prescaler producing one tick per converter clock period.
`timescale 1ns/1ps
module acc_clkdiv
  import acc_pkg::*;
(
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Control.
  input  wire logic             run,
  input  wire logic [PRS_W-1:0] prescale_value,
  input  wire logic             double_speed,
  // Tick out.
  output logic                  tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } acc_div_t;

  acc_div_t         st_r;
  acc_div_t         st_nxt;
  logic [DIV_W-1:0] period;

  // A zero prescale is treated as one so the converter clock never stops.
  always_comb begin
    period = DIV_W'(prescale_value == '0 ? 1 : prescale_value) *
             DIV_W'(double_speed ? DIV_X2 : DIV_STD);
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= period - DIV_W'(1)) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : acc_clkdiv

// [hdl/acc_pkg.sv]
// Constants and types shared by the converter control block.
package acc_pkg;
  localparam int          CLK_MHZ     = 100;
  localparam int          SETUP_NS    = 4000;
  localparam int          SETUP_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          SETUP_W     = $clog2(SETUP_CYC + 1);
  localparam int          TOTAL_NS    = 20000;
  localparam int          TOTAL_CYC   = TOTAL_NS * CLK_MHZ / 1000;
  localparam int          CONV_CLKS   = 11;
  localparam int          CNV_W       = 4;
  localparam int          N_CHAN      = 8;
  localparam int          CH_W        = 3;
  localparam int          PRS_W       = 5;
  localparam int          DIV_W       = 7;
  localparam int          RES_W       = 10;
  localparam int          AIN_W       = 12;
  localparam int          OTH_W       = 8;
  localparam int          REG_W       = 8;
  localparam int          LOW_BITS    = 2;
  localparam int          DIV_STD     = 4;
  localparam int          DIV_X2      = 2;
  localparam logic [9:0]  RES_FULL    = 10'h3FF;
  localparam logic [9:0]  RES_ZERO    = 10'h000;
  localparam logic [9:0]  STD_MASK    = 10'h3FC;
  localparam logic [7:0]  REG_RESET   = 8'h00;

  typedef enum logic [1:0] {ACC_IDLE, ACC_SETUP, ACC_CONV} acc_state_t;
endpackage : acc_pkg

// [hdl/acc_sync2.sv]
// Two-flop synchroniser for a word that the analog front end holds steady.
`timescale 1ns/1ps
module acc_sync2
  import acc_pkg::*;
#(
  parameter int W = AIN_W
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Data.
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acc_sync_t;

  acc_sync_t st_r;
  acc_sync_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign d_out = st_r.s2;
endmodule : acc_sync2

// [hdl/acc_top.sv]
// Conversion control for the eight-input analog-to-digital converter.
`timescale 1ns/1ps
module acc_top
  import acc_pkg::*;
(
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Software control bits.
  input  wire logic             sw_start_set,
  input  wire logic             sw_done_clear,
  input  wire logic             converter_enable,
  input  wire logic             quiet_convert_select,
  input  wire logic [CH_W-1:0]  channel_select,
  input  wire logic             done_irq_enable,
  input  wire logic [PRS_W-1:0] prescale_value,
  input  wire logic             double_speed,
  input  wire logic [REG_W-1:0] analog_pin_config,
  // Other interrupt sources of the chip.
  input  wire logic [OTH_W-1:0] other_irq_req,
  // Analog front end.
  input  wire logic [AIN_W-1:0] selected_analog_input,
  // Status and results.
  output logic                  start_busy_bit_r,
  output logic                  conv_done_flag_r,
  output logic                  adc_irq_r,
  output logic [REG_W-1:0]      result_high_reg_r,
  output logic [REG_W-1:0]      result_low_reg_r,
  // Analog and pin control.
  output logic [CH_W-1:0]       mux_select_r,
  output logic                  analog_standby_r,
  output logic [REG_W-1:0]      pin_analog_r,
  // Processor control.
  output logic                  cpu_halt_r,
  output logic [OTH_W-1:0]      other_irq_out_r
);
  // Width of the busy-time counter, sized for the nominal conversion time.
  localparam int TOT_W = $clog2(TOTAL_CYC + 1);

  typedef struct packed {
    acc_state_t         st;
    logic               busy;
    logic               done;
    logic               irq;
    logic               prec;
    logic               halt;
    logic               standby;
    logic [CH_W-1:0]    mux;
    logic [REG_W-1:0]   pin;
    logic [REG_W-1:0]   res_h;
    logic [REG_W-1:0]   res_l;
    logic [SETUP_W-1:0] scnt;
    logic [CNV_W-1:0]   tcnt;
    logic [OTH_W-1:0]   pend;
    logic [OTH_W-1:0]   oirq;
    logic [TOT_W-1:0]   bcnt;
  } acc_ctl_t;

  acc_ctl_t         st_r;
  acc_ctl_t         st_nxt;
  logic             tick;
  logic [AIN_W-1:0] ain_sync;
  logic             finish;
  logic [RES_W-1:0] conv_val;

  // The front end holds its word steady through the conversion, so a
  // plain two-flop pass per bit is enough here.
  acc_sync2 #(
    .W (AIN_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d_in    (selected_analog_input),
    .d_out   (ain_sync)
  );

  acc_clkdiv u_div (
    .sys_clk        (sys_clk),
    .rst_b          (rst_b),
    .run            (st_r.st == ACC_CONV),
    .prescale_value (prescale_value),
    .double_speed   (double_speed),
    .tick           (tick)
  );

  // The front end word is signed so that levels beyond either rail show.
  function automatic logic [RES_W-1:0] clamp_code(input logic [AIN_W-1:0] a);
    logic signed [AIN_W-1:0] s;
    s = signed'(a);
    if (s < 0) begin
      clamp_code = RES_ZERO;
    end else if (s > signed'(AIN_W'(RES_FULL))) begin
      clamp_code = RES_FULL;
    end else begin
      clamp_code = a[RES_W-1:0];
    end
  endfunction : clamp_code

  always_comb begin
    st_nxt  = st_r;
    finish  = 1'b0;
    conv_val = clamp_code(ain_sync);
    if (!st_r.prec) begin
      conv_val = conv_val & STD_MASK;
    end
    st_nxt.standby = !converter_enable;
    st_nxt.pin     = analog_pin_config;

    unique case (st_r.st)
      ACC_IDLE: begin
        // Start is taken only when enabled and idle.
        if (sw_start_set && converter_enable) begin
          st_nxt.st   = ACC_SETUP;
          st_nxt.busy = 1'b1;
          st_nxt.mux  = channel_select;
          st_nxt.prec = quiet_convert_select;
          st_nxt.halt = quiet_convert_select;
          st_nxt.scnt = '0;
          st_nxt.tcnt = '0;
        end
      end
      ACC_SETUP: begin
        if (st_r.scnt == SETUP_W'(SETUP_CYC - 1)) begin
          st_nxt.st = ACC_CONV;
        end else begin
          st_nxt.scnt = st_r.scnt + SETUP_W'(1);
        end
      end
      ACC_CONV: begin
        if (tick) begin
          if (st_r.tcnt == CNV_W'(CONV_CLKS - 1)) begin
            finish = 1'b1;
          end else begin
            st_nxt.tcnt = st_r.tcnt + CNV_W'(1);
          end
        end
      end
    endcase

    // Dropping the enable aborts a running conversion without a result.
    if (!converter_enable && st_r.st != ACC_IDLE) begin
      st_nxt.st   = ACC_IDLE;
      st_nxt.busy = 1'b0;
      st_nxt.halt = 1'b0;
      finish      = 1'b0;
    end
    if (finish) begin
      st_nxt.st    = ACC_IDLE;
      st_nxt.busy  = 1'b0;
      st_nxt.halt  = 1'b0;
      st_nxt.res_h = conv_val[RES_W-1:LOW_BITS];
      st_nxt.res_l = {{(REG_W - LOW_BITS){1'b0}}, conv_val[LOW_BITS-1:0]};
    end

    // A completion in the same cycle as a clear keeps the flag set.
    st_nxt.done = (st_r.done && !sw_done_clear) || finish;
    st_nxt.irq  = st_nxt.done && done_irq_enable;

    // Busy cycles are counted only so that the nominal conversion time can be watched.
    st_nxt.bcnt = st_nxt.busy ? st_r.bcnt + TOT_W'(1) : '0;

    // Other requests wait while the processor is halted.
    if (st_nxt.halt) begin
      st_nxt.pend = st_r.pend | other_irq_req;
      st_nxt.oirq = '0;
    end else begin
      st_nxt.pend = '0;
      st_nxt.oirq = st_r.pend | other_irq_req;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r       <= '0;
      st_r.st    <= ACC_IDLE;
      st_r.res_h <= REG_RESET;
      st_r.res_l <= REG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign start_busy_bit_r  = st_r.busy;
  assign conv_done_flag_r  = st_r.done;
  assign adc_irq_r         = st_r.irq;
  assign result_high_reg_r = st_r.res_h;
  assign result_low_reg_r  = st_r.res_l;
  assign mux_select_r      = st_r.mux;
  assign analog_standby_r  = st_r.standby;
  assign pin_analog_r      = st_r.pin;
  assign cpu_halt_r        = st_r.halt;
  assign other_irq_out_r   = st_r.oirq;

  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  localparam int SETUP_MIN = SETUP_CYC;

  AST_START_BUSY: assert property (
    st_r.st == ACC_IDLE && sw_start_set && converter_enable |=> start_busy_bit_r && st_r.st == ACC_SETUP)
    else $error("Start did not raise busy.");

  AST_BUSY_CLEAR: assert property (
    $fell(start_busy_bit_r) && $past(converter_enable) |-> conv_done_flag_r)
    else $error("Busy fell without completion.");

  AST_BUSY_STABLE: assert property (
    start_busy_bit_r && st_r.st == ACC_SETUP && converter_enable |=> start_busy_bit_r)
    else $error("Busy dropped during setup.");

  AST_DONE_HOLD: assert property (
    conv_done_flag_r && !sw_done_clear |=> conv_done_flag_r)
    else $error("Done flag cleared without software.");

  AST_IRQ_LEVEL: assert property (
    ##1 adc_irq_r == (conv_done_flag_r && $past(done_irq_enable)))
    else $error("Interrupt does not follow done and enable.");

  AST_MUX_HELD: assert property (
    start_busy_bit_r && sw_start_set && converter_enable && !finish |=> $stable(mux_select_r) && start_busy_bit_r)
    else $error("Start during conversion disturbed it.");

  AST_STD_LOW: assert property (
    $rose(conv_done_flag_r) && !st_r.prec |-> result_low_reg_r == REG_RESET)
    else $error("Standard conversion kept low bits.");

  AST_HALT_MASK: assert property (
    cpu_halt_r |-> other_irq_out_r == '0)
    else $error("Interrupt passed while halted.");

  AST_SETUP_TIME: assert property (
    st_r.st == ACC_SETUP && $past(st_r.st) == ACC_IDLE |-> (st_r.st == ACC_SETUP)[*8])
    else $error("Setup interval too short.");

  AST_SETUP_EXIT: assert property (
    st_r.st == ACC_SETUP ##1 st_r.st == ACC_CONV |-> $past(st_r.scnt) == SETUP_W'(SETUP_MIN - 1))
    else $error("Setup left at wrong count.");

  AST_STANDBY: assert property (
    !converter_enable |=> !start_busy_bit_r && analog_standby_r)
    else $error("Conversion in standby.");

  AST_TOTAL_TIME: assert property (
    start_busy_bit_r
    |-> st_r.bcnt < TOT_W'(TOTAL_CYC))
    else $error("Conversion longer than the nominal time.");

  AST_IDLE_QUIET: assert property (
    st_r.st == ACC_IDLE
    |-> !start_busy_bit_r && !cpu_halt_r)
    else $error("Busy or halt while idle.");

  AST_BUSY_STATE: assert property (
    st_r.st != ACC_IDLE
    |-> start_busy_bit_r)
    else $error("Busy low while converting.");

  AST_START_NO_RESTART: assert property (
    st_r.st == ACC_SETUP && sw_start_set && converter_enable
    |=> st_r.scnt != '0)
    else $error("Start during setup restarted it.");

  AST_DISABLED_START: assert property (
    !converter_enable && st_r.st == ACC_IDLE
    |=> st_r.st == ACC_IDLE)
    else $error("Start taken in standby.");

  AST_DONE_SET: assert property (
    finish
    |=> conv_done_flag_r)
    else $error("Completion did not set done.");

  AST_DONE_CLEAR: assert property (
    conv_done_flag_r && sw_done_clear && !finish
    |=> !conv_done_flag_r)
    else $error("Software clear of done ignored.");

  AST_DONE_RISE: assert property (
    $rose(conv_done_flag_r)
    |-> $past(finish))
    else $error("Done set without completion.");

  AST_MUX_LATCH: assert property (
    st_r.st == ACC_IDLE && sw_start_set && converter_enable
    |=> mux_select_r == $past(channel_select))
    else $error("Channel not latched at start.");

  AST_HALT_LATCH: assert property (
    st_r.st == ACC_IDLE && sw_start_set && converter_enable
    |=> cpu_halt_r == $past(quiet_convert_select) && st_r.prec == $past(quiet_convert_select))
    else $error("Precision mode not latched at start.");

  AST_HALT_BUSY: assert property (
    cpu_halt_r
    |-> start_busy_bit_r)
    else $error("Halt outside a conversion.");

  AST_HALT_WAKE: assert property (
    $fell(cpu_halt_r) && $past(converter_enable)
    |-> conv_done_flag_r)
    else $error("Halt released without end of conversion.");

  AST_IRQ_DONE: assert property (
    adc_irq_r
    |-> conv_done_flag_r)
    else $error("Interrupt without done flag.");

  AST_IRQ_RELEASE: assert property (
    $fell(cpu_halt_r)
    |-> other_irq_out_r == ($past(st_r.pend) | $past(other_irq_req)))
    else $error("Held interrupts not released.");

  AST_IRQ_PASS: assert property (
    !cpu_halt_r && !$past(cpu_halt_r)
    |-> other_irq_out_r == $past(other_irq_req))
    else $error("Interrupt not forwarded while running.");

  AST_PIN_FOLLOW: assert property (
    1'b1
    |=> pin_analog_r == $past(analog_pin_config))
    else $error("Pin configuration not followed.");

  AST_STANDBY_LEVEL: assert property (
    1'b1
    |=> analog_standby_r == !$past(converter_enable))
    else $error("Standby does not follow enable.");

  AST_RES_SPLIT: assert property (
    $rose(conv_done_flag_r)
    |-> result_low_reg_r[REG_W-1:LOW_BITS] == '0)
    else $error("Low result register upper bits set.");

  AST_RES_HOLD: assert property (
    !finish
    |=> $stable(result_high_reg_r) && $stable(result_low_reg_r))
    else $error("Result changed without completion.");

  AST_SETUP_START: assert property (
    st_r.st == ACC_SETUP && $past(st_r.st) == ACC_IDLE
    |-> st_r.scnt == '0)
    else $error("Setup did not start from zero.");

  AST_CONV_COUNT: assert property (
    st_r.st == ACC_CONV && !tick && converter_enable
    |=> $stable(st_r.tcnt))
    else $error("Conversion counted without a converter clock.");

  COV_STD: cover property ($rose(conv_done_flag_r) && !st_r.prec);
  COV_PREC: cover property ($fell(cpu_halt_r) && conv_done_flag_r);
  COV_SET_CLR: cover property ($past(sw_done_clear) && $rose(conv_done_flag_r));
  COV_ABORT: cover property ($fell(start_busy_bit_r) && !conv_done_flag_r);
  COV_RELEASE: cover property ($fell(cpu_halt_r) && other_irq_out_r != '0);
endmodule : acc_top
